// ---- logic/adc_control_interface.sv ----
/*
 * Control logic of a self-calibrating successive-approximation converter: host pin
 * port, conversion sequencing, calibration modes, APB register slave and interrupt.
 * Assumes all pin inputs are synchronous to i_core_clk, which is the master clock.
 */
// Notes on behaviour
// - When the reset calibration ends, conversion-done goes low in every operating mode.
// - In loopback each sample is tracked and converted in 64 master clocks, 84 in interleave mode.
// - Reset calibration takes 58,280 clocks; interleave completes a pass every 2,014 conversions.
// - Burst calibration works, though the host is advised not to use it.
// - Calibration keeps a 15-bit trim word, an eighth of a 12-bit step.
// - With reset low, a falling sample-and-convert input holds and starts a conversion.
// - A latched high burst request starts burst; a low one with sample input high stops it.
// - A latched low interleave request starts interleave mode and a high one ends it.
// - Select and read low drive data when the address line is 1, status when 0 with sample high.
// - The data bus floats one clock after select or read strobe is high.
// - Reset pin high, or sample, select and address all low, resets the logic.
// - Burst and interleave requests are sampled on the rising edge of select.
// - Conversion-done rises again on the first read or when a new conversion starts.
// - In interleave mode each conversion lasts 20 clocks longer.
`timescale 1ns/1ps
module adc_control_interface #(
	parameter int CONV_CYCLES = adc_ctl_pkg::CONV_CYCLES_DEF,
	parameter int CAL_CYCLES = adc_ctl_pkg::CAL_CYCLES_DEF
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_hold_n,
	input wire logic i_sel_n,
	input wire logic i_rd_n,
	input wire logic i_read_target_sel,
	input wire logic i_rst_pin,
	input wire logic i_burst_cal,
	input wire logic i_interleave_tune_n,
	input wire logic [adc_ctl_pkg::RESULT_W-1:0] i_sar_result,
	input wire logic [adc_ctl_pkg::TRIM_W-1:0] i_cal_word,
	output logic [adc_ctl_pkg::BUS_W-1:0] o_data,
	output logic o_data_oe,
	output logic o_conv_done_n,
	output logic o_tracking_done_n,
	output logic o_irq,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [adc_ctl_pkg::APB_AW-1:0] i_paddr,
	input wire logic [adc_ctl_pkg::APB_DW-1:0] i_pwdata,
	output logic [adc_ctl_pkg::APB_DW-1:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr
);

	// ----------------------------------------
	// phase lengths
	// ----------------------------------------
	localparam logic [adc_ctl_pkg::CNT_W-1:0] CONV_LEN = adc_ctl_pkg::CNT_W'(CONV_CYCLES);
	localparam logic [adc_ctl_pkg::CNT_W-1:0] CONV_LEN_INTL =
		adc_ctl_pkg::CNT_W'(CONV_CYCLES + adc_ctl_pkg::INTERLEAVE_EXTRA);
	localparam logic [adc_ctl_pkg::CNT_W-1:0] TRACK_LEN =
		adc_ctl_pkg::CNT_W'(adc_ctl_pkg::LOOP_CYCLES - CONV_CYCLES);

	adc_ctl_pkg::core_state_t s_q;
	adc_ctl_pkg::core_state_t s_d;

	logic sw_rst;
	logic rst_any;
	logic hold_fall;
	logic sel_rise;
	logic sel_fall;
	logic rden;
	logic read_start;
	logic apb_access;
	logic apb_commit;
	logic tmr_start;
	logic [adc_ctl_pkg::CNT_W-1:0] tmr_load;
	logic tmr_done;
	logic cal_restart;
	logic cal_run;
	logic conv_step;
	logic cal_done;
	logic [adc_ctl_pkg::TRIM_W-1:0] trim;
	logic [adc_ctl_pkg::STS_W-1:0] status;
	logic [adc_ctl_pkg::IRQ_W-1:0] irq_set;

	// ----------------------------------------
	// pin decode
	// ----------------------------------------
	// software reset: sample, select and address line all low together
	assign sw_rst = ~i_hold_n & ~i_sel_n & ~i_read_target_sel;
	assign rst_any = i_rst_pin | sw_rst;
	assign hold_fall = s_q.hold_n_p & ~i_hold_n;
	assign sel_rise = ~s_q.sel_n_p & i_sel_n;
	assign sel_fall = s_q.sel_n_p & ~i_sel_n;
	assign rden = ~i_sel_n & ~i_rd_n;
	assign read_start = rden & ~s_q.rden_p;
	assign apb_access = i_psel & i_penable;
	assign apb_commit = apb_access & s_q.pready;

	// status byte shared by the pin port and the register bus
	always_comb begin
		status = '0;
		status[adc_ctl_pkg::STS_CONV] = (s_q.mode == adc_ctl_pkg::ST_CONV);
		status[adc_ctl_pkg::STS_CAL] = cal_run;
		status[adc_ctl_pkg::STS_BURST] = s_q.burst_on;
		status[adc_ctl_pkg::STS_INTL] = s_q.intl_on;
		status[adc_ctl_pkg::STS_TRACKED] = ~s_q.track_done_n;
		status[adc_ctl_pkg::STS_LOOP] = s_q.loopback;
	end

	// ----------------------------------------
	// sub-blocks
	// ----------------------------------------
	cycle_timer u_timer (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.i_start(tmr_start),
		.i_load(tmr_load),
		.o_busy(),
		.o_done(tmr_done)
	);

	cal_engine #(
		.CAL_CYCLES(CAL_CYCLES)
	) u_cal (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.i_restart(cal_restart),
		.i_run(cal_run),
		.i_conv_step(conv_step),
		.i_cal_word(i_cal_word),
		.o_done(cal_done),
		.o_trim(trim)
	);

	// calibration clocks run only in reset and burst calibration
	always_comb begin
		cal_run = (s_q.mode == adc_ctl_pkg::ST_RST_CAL) | (s_q.mode == adc_ctl_pkg::ST_BURST);
		cal_restart = (s_q.mode == adc_ctl_pkg::ST_IDLE);
	end

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		tmr_start = 1'b0;
		tmr_load = TRACK_LEN;
		conv_step = 1'b0;
		irq_set = '0;
		s_d.hold_n_p = i_hold_n;
		s_d.sel_n_p = i_sel_n;
		s_d.rden_p = rden;

		// requests are sampled when select rises
		if (sel_rise) begin
			s_d.cal_lat = i_burst_cal;
			s_d.intl_lat = i_interleave_tune_n;
		end
		// and acted on when select next falls
		if (sel_fall) begin
			if (s_q.cal_lat) begin
				s_d.burst_on = 1'b1;
			end else if (i_hold_n) begin
				s_d.burst_on = 1'b0;
			end
			s_d.intl_on = ~s_q.intl_lat;
		end

		// a read re-arms conversion-done; completion below wins in the same cycle
		if (read_start) begin
			s_d.conv_done_n = 1'b1;
			irq_set[adc_ctl_pkg::IRQ_READ] = 1'b1;
		end

		if (cal_done) begin
			irq_set[adc_ctl_pkg::IRQ_CAL] = 1'b1;
		end

		case (s_q.mode)
			adc_ctl_pkg::ST_IDLE: begin
				s_d.mode = adc_ctl_pkg::ST_RST_CAL;
				s_d.conv_done_n = 1'b1;
			end
			adc_ctl_pkg::ST_RST_CAL: begin
				if (cal_done) begin
					s_d.conv_done_n = 1'b0;
					s_d.mode = adc_ctl_pkg::ST_TRACK;
					tmr_start = 1'b1;
				end
			end
			adc_ctl_pkg::ST_TRACK: begin
				if (s_q.burst_on) begin
					s_d.mode = adc_ctl_pkg::ST_BURST;
					s_d.track_done_n = 1'b1;
				// loopback enabled after track time ran out starts at once, no stall
				end else if (hold_fall | (s_q.loopback & (tmr_done | ~s_q.track_done_n))) begin
					s_d.mode = adc_ctl_pkg::ST_CONV;
					s_d.conv_done_n = 1'b1;
					s_d.track_done_n = 1'b1;
					tmr_start = 1'b1;
					tmr_load = s_q.intl_on ? CONV_LEN_INTL : CONV_LEN;
				end else if (tmr_done) begin
					s_d.track_done_n = 1'b0;
				end
			end
			adc_ctl_pkg::ST_CONV: begin
				if (tmr_done) begin
					s_d.result = i_sar_result;
					s_d.conv_done_n = 1'b0;
					conv_step = s_q.intl_on;
					irq_set[adc_ctl_pkg::IRQ_CONV] = 1'b1;
					// a burst request waits for the running conversion
					s_d.mode = s_q.burst_on ? adc_ctl_pkg::ST_BURST : adc_ctl_pkg::ST_TRACK;
					tmr_start = ~s_q.burst_on;
				end
			end
			adc_ctl_pkg::ST_BURST: begin
				if (~s_q.burst_on) begin
					s_d.mode = adc_ctl_pkg::ST_TRACK;
					tmr_start = 1'b1;
				end
			end
			default: begin
				s_d.mode = adc_ctl_pkg::ST_IDLE;
			end
		endcase

		// pin port read path, one cycle behind the strobes
		s_d.data_oe = rden & ~rst_any & (i_read_target_sel | i_hold_n);
		if (i_read_target_sel) begin
			s_d.data = {s_q.result, {adc_ctl_pkg::RESULT_PAD{1'b0}}};
		end else begin
			s_d.data = {{(adc_ctl_pkg::BUS_W - adc_ctl_pkg::STS_W){1'b0}}, status};
		end

		// hardware or software reset holds the core idle; calibration restarts after
		if (rst_any) begin
			s_d.mode = adc_ctl_pkg::ST_IDLE;
			s_d.cal_lat = 1'b0;
			s_d.intl_lat = 1'b1; // idle request level: a bare select fall keeps interleave off
			s_d.burst_on = 1'b0;
			s_d.intl_on = 1'b0;
			s_d.conv_done_n = 1'b1;
			s_d.track_done_n = 1'b1;
			s_d.result = '0;
			s_d.data_oe = 1'b0;
			tmr_start = 1'b0;
			conv_step = 1'b0;
			irq_set = '0;
		end

		// ----------------------------------------
		// apb slave: one wait state, then the transfer completes
		// ----------------------------------------
		s_d.pready = apb_access & ~s_q.pready;
		if (apb_access & ~s_q.pready) begin
			s_d.pslverr = 1'b0;
			s_d.prdata = '0;
			case (i_paddr)
				adc_ctl_pkg::ADDR_CTRL: s_d.prdata[adc_ctl_pkg::CTRL_LOOPBACK] = s_q.loopback;
				adc_ctl_pkg::ADDR_STATUS: s_d.prdata[adc_ctl_pkg::STS_W-1:0] = status;
				adc_ctl_pkg::ADDR_RESULT: s_d.prdata[adc_ctl_pkg::RESULT_W-1:0] = s_q.result;
				adc_ctl_pkg::ADDR_TRIM: s_d.prdata[adc_ctl_pkg::TRIM_W-1:0] = trim;
				adc_ctl_pkg::ADDR_IRQ_STAT: s_d.prdata[adc_ctl_pkg::IRQ_W-1:0] = s_q.irq_stat;
				adc_ctl_pkg::ADDR_IRQ_MASK: s_d.prdata[adc_ctl_pkg::IRQ_W-1:0] = s_q.irq_mask;
				default: s_d.pslverr = 1'b1;
			endcase
		end
		if (apb_commit & i_pwrite & ~s_q.pslverr) begin
			case (i_paddr)
				adc_ctl_pkg::ADDR_CTRL: s_d.loopback = i_pwdata[adc_ctl_pkg::CTRL_LOOPBACK];
				adc_ctl_pkg::ADDR_IRQ_STAT:
					s_d.irq_stat = s_q.irq_stat & ~i_pwdata[adc_ctl_pkg::IRQ_W-1:0];
				adc_ctl_pkg::ADDR_IRQ_MASK: s_d.irq_mask = i_pwdata[adc_ctl_pkg::IRQ_W-1:0];
				default: s_d.irq_stat = s_d.irq_stat;
			endcase
		end

		// ----------------------------------------
		// interrupt: sticky events, set wins over a same-cycle clear
		// ----------------------------------------
		s_d.irq_stat = s_d.irq_stat | irq_set;
		s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
	end

	// register the state; clock enable low freezes everything
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_q <= adc_ctl_pkg::CORE_RESET;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// outputs straight from the state register
	// ----------------------------------------
	assign o_data = s_q.data;
	assign o_data_oe = s_q.data_oe;
	assign o_conv_done_n = s_q.conv_done_n;
	assign o_tracking_done_n = s_q.track_done_n;
	assign o_irq = s_q.irq;
	assign o_prdata = s_q.prdata;
	assign o_pready = s_q.pready;
	assign o_pslverr = s_q.pslverr;

endmodule : adc_control_interface

// ---- logic/adc_ctl_pkg.sv ----
/*
 * Shared constants, state encodings and state structs of the converter control block.
 * Assumes a single 25 MHz core clock that also serves as the converter master clock.
 */
package adc_ctl_pkg;

	// ----------------------------------------
	// bus and data widths
	// ----------------------------------------
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;
	localparam int BUS_W = 16;
	localparam int RESULT_W = 12;
	localparam int TRIM_W = 15;
	localparam int STS_W = 8;
	localparam int CNT_W = 7;
	localparam int CAL_CNT_W = 17;
	localparam int CONV_CNT_W = 11;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;
	localparam logic [APB_AW-1:0] ADDR_RESULT = 8'h08;
	localparam logic [APB_AW-1:0] ADDR_TRIM = 8'h0C;
	localparam logic [APB_AW-1:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [APB_AW-1:0] ADDR_IRQ_MASK = 8'h14;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_LOOPBACK = 0;
	localparam int STS_CONV = 0;
	localparam int STS_CAL = 1;
	localparam int STS_BURST = 2;
	localparam int STS_INTL = 3;
	localparam int STS_TRACKED = 4;
	localparam int STS_LOOP = 5;
	localparam int IRQ_W = 3;
	localparam int IRQ_CONV = 0;
	localparam int IRQ_CAL = 1;
	localparam int IRQ_READ = 2;
	localparam int RESULT_PAD = 4;

	// ----------------------------------------
	// timing counts in master clock cycles, except CAL_CONVS in conversions
	// ----------------------------------------
	localparam int LOOP_CYCLES = 64;
	localparam int CONV_CYCLES_DEF = 46;
	localparam int INTERLEAVE_EXTRA = 20;
	localparam int CAL_CYCLES_DEF = 58280;
	localparam int CAL_CONVS = 2014;

	// ----------------------------------------
	// operating modes, gray coded along the usual path
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RST_CAL = 3'b001,
		ST_TRACK = 3'b011,
		ST_CONV = 3'b010,
		ST_BURST = 3'b110
	} mode_t;

	// ----------------------------------------
	// state structs
	// ----------------------------------------
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic busy;
	} timer_state_t;

	typedef struct packed {
		logic [CAL_CNT_W-1:0] cyc;
		logic [CONV_CNT_W-1:0] convs;
		logic [TRIM_W-1:0] trim;
	} cal_state_t;

	typedef struct packed {
		mode_t mode;
		logic hold_n_p;
		logic sel_n_p;
		logic rden_p;
		logic cal_lat;
		logic intl_lat;
		logic burst_on;
		logic intl_on;
		logic loopback;
		logic conv_done_n;
		logic track_done_n;
		logic [RESULT_W-1:0] result;
		logic [BUS_W-1:0] data;
		logic data_oe;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic irq;
		logic pready;
		logic pslverr;
		logic [APB_DW-1:0] prdata;
	} core_state_t;

	localparam core_state_t CORE_RESET = '{
		mode: ST_IDLE,
		hold_n_p: 1'b1,
		sel_n_p: 1'b1,
		intl_lat: 1'b1,
		conv_done_n: 1'b1,
		track_done_n: 1'b1,
		default: '0
	};

endpackage : adc_ctl_pkg

// ---- logic/cycle_timer.sv ----
/*
 * Down counter that times one phase of the converter sequence.
 * Assumes the caller restarts it on the cycle in which done is seen.
 */
`timescale 1ns/1ps
module cycle_timer (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_start,
	input wire logic [adc_ctl_pkg::CNT_W-1:0] i_load,
	output logic o_busy,
	output logic o_done
);

	adc_ctl_pkg::timer_state_t s_q;
	adc_ctl_pkg::timer_state_t s_d;

	// ----------------------------------------
	// counting
	// ----------------------------------------
	// done marks the last cycle of the phase, so a restart adds no gap
	assign o_done = s_q.busy & (s_q.cnt == adc_ctl_pkg::CNT_W'(1));
	assign o_busy = s_q.busy;

	// next state: start wins over the running count
	always_comb begin
		s_d = s_q;
		if (i_start) begin
			s_d.cnt = i_load;
			s_d.busy = 1'b1;
		end else if (s_q.busy) begin
			s_d.cnt = s_q.cnt - adc_ctl_pkg::CNT_W'(1);
			s_d.busy = (s_q.cnt != adc_ctl_pkg::CNT_W'(1));
		end
	end

	// register the state
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_q <= '0;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

endmodule : cycle_timer

// ---- logic/cal_engine.sv ----
/*
 * Calibration progress: counts master clock cycles for reset and burst calibration
 * and conversions for interleave calibration, and keeps the 15-bit trim word.
 * Assumes the trim word from the analog calibration loop is valid when a pass ends.
 */
`timescale 1ns/1ps
module cal_engine #(
	parameter int CAL_CYCLES = adc_ctl_pkg::CAL_CYCLES_DEF
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_restart,
	input wire logic i_run,
	input wire logic i_conv_step,
	input wire logic [adc_ctl_pkg::TRIM_W-1:0] i_cal_word,
	output logic o_done,
	output logic [adc_ctl_pkg::TRIM_W-1:0] o_trim
);

	localparam logic [adc_ctl_pkg::CAL_CNT_W-1:0] CYC_LAST =
		adc_ctl_pkg::CAL_CNT_W'(CAL_CYCLES - 1);
	localparam logic [adc_ctl_pkg::CONV_CNT_W-1:0] CONV_LAST =
		adc_ctl_pkg::CONV_CNT_W'(adc_ctl_pkg::CAL_CONVS - 1);

	adc_ctl_pkg::cal_state_t s_q;
	adc_ctl_pkg::cal_state_t s_d;
	logic cyc_end;
	logic conv_end;

	// ----------------------------------------
	// pass completion
	// ----------------------------------------
	assign cyc_end = i_run & (s_q.cyc == CYC_LAST);
	assign conv_end = i_conv_step & (s_q.convs == CONV_LAST);
	assign o_done = cyc_end | conv_end;
	assign o_trim = s_q.trim;

	// burst resumes where the last pass stopped; only restart or a finished pass clears progress
	always_comb begin
		s_d = s_q;
		if (i_restart) begin
			s_d.cyc = '0;
			s_d.convs = '0;
		end else begin
			if (i_run) begin
				s_d.cyc = cyc_end ? '0 : s_q.cyc + adc_ctl_pkg::CAL_CNT_W'(1);
			end
			if (i_conv_step) begin
				s_d.convs = conv_end ? '0 : s_q.convs + adc_ctl_pkg::CONV_CNT_W'(1);
			end
		end
		if (o_done) begin
			s_d.trim = i_cal_word;
		end
	end

	// register the state
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_q <= '0;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

endmodule : cal_engine

// ---- bench/adc_ctl_properties.sv ----
/*
 * Checker for the converter control block: pin port, reset and APB timing.
 * Assumes a bind onto adc_control_interface and one clock domain.
 */
`timescale 1ns/1ps
module adc_ctl_properties #(
	parameter int CONV_CYCLES = adc_ctl_pkg::CONV_CYCLES_DEF
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_hold_n,
	input wire logic i_sel_n,
	input wire logic i_rd_n,
	input wire logic i_read_target_sel,
	input wire logic i_rst_pin,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic [adc_ctl_pkg::APB_AW-1:0] i_paddr,
	input wire logic [adc_ctl_pkg::BUS_W-1:0] o_data,
	input wire logic o_data_oe,
	input wire logic o_conv_done_n,
	input wire logic o_tracking_done_n,
	input wire logic o_pready,
	input wire logic o_pslverr
);
	localparam int CM1 = CONV_CYCLES - 1;
	localparam int XTRA = adc_ctl_pkg::INTERLEAVE_EXTRA;

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking dc @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	// a host-started conversion re-arms done one cycle later
	sequence conv_go;
		$fell(i_hold_n) && i_sel_n ##1 $rose(o_conv_done_n);
	endsequence
	// done falls after the normal or the interleave length
	sequence conv_end;
		##CM1 o_conv_done_n ##1 (!o_conv_done_n or (o_conv_done_n ##XTRA !o_conv_done_n));
	endsequence

	a_reset_quiet: assert property ($fell(i_srst) |-> !o_data_oe && o_conv_done_n && !o_pready)
		else $error("outputs not quiet after reset");
	a_bus_float: assert property ((i_sel_n || i_rd_n) |=> !o_data_oe)
		else $error("data bus driven while deselected");
	a_data_read: assert property (!i_sel_n && !i_rd_n && i_read_target_sel && !i_rst_pin
		|=> o_data_oe && o_data[3:0] == 4'h0)
		else $error("data read not driven");
	a_status_read: assert property (!i_sel_n && !i_rd_n && !i_read_target_sel && i_hold_n
		&& !i_rst_pin |=> o_data_oe && o_data[15:8] == 8'h00)
		else $error("status read not driven");
	a_pin_reset: assert property (i_rst_pin |=> o_conv_done_n && o_tracking_done_n)
		else $error("pin reset ignored");
	a_soft_reset: assert property (!i_hold_n && !i_sel_n && !i_read_target_sel
		|=> o_conv_done_n [*2])
		else $error("software reset ignored");
	a_read_rearm: assert property ($fell(i_rd_n) && !i_sel_n && !o_conv_done_n
		|=> ##[0:1] o_conv_done_n)
		else $error("done not re-armed by read");
	a_conv_length: assert property (conv_go |-> conv_end)
		else $error("conversion length wrong");
	a_apb_ready: assert property (i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
		else $error("apb ready timing wrong");
	a_unmapped_err: assert property (i_psel && i_penable && o_pready && i_paddr > 8'h14
		|-> o_pslverr)
		else $error("unmapped access not refused");
endmodule : adc_ctl_properties

bind adc_control_interface adc_ctl_properties #(.CONV_CYCLES(CONV_CYCLES)) u_props (
	.i_core_clk(i_core_clk),
	.i_srst(i_srst),
	.i_hold_n(i_hold_n),
	.i_sel_n(i_sel_n),
	.i_rd_n(i_rd_n),
	.i_read_target_sel(i_read_target_sel),
	.i_rst_pin(i_rst_pin),
	.i_psel(i_psel),
	.i_penable(i_penable),
	.i_paddr(i_paddr),
	.o_data(o_data),
	.o_data_oe(o_data_oe),
	.o_conv_done_n(o_conv_done_n),
	.o_tracking_done_n(o_tracking_done_n),
	.o_pready(o_pready),
	.o_pslverr(o_pslverr)
);

// ---- bench/host_model.sv ----
/*
 * Host processor model on the pin port: conversion, pin reads, mode requests.
 * Assumes the caller invokes one task at a time, all timed on the core clock.
 */
`timescale 1ns/1ps
module host_model (
	input wire logic i_core_clk,
	input wire logic [adc_ctl_pkg::BUS_W-1:0] i_data,
	output logic o_hold_n,
	output logic o_sel_n,
	output logic o_rd_n,
	output logic o_read_target_sel,
	output logic o_burst_cal,
	output logic o_interleave_tune_n
);
	// idle levels: address high so a select never resets by accident
	initial begin
		o_hold_n = 1'b1;
		o_sel_n = 1'b1;
		o_rd_n = 1'b1;
		o_read_target_sel = 1'b1;
		o_burst_cal = 1'b0;
		o_interleave_tune_n = 1'b1;
	end

	// hold low three cycles, longer than one clock plus 50 ns
	task automatic convert();
		@(posedge i_core_clk);
		o_hold_n <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		o_hold_n <= 1'b1;
	endtask : convert

	// select and read low together, data taken two edges later
	task automatic pin_read(input logic t, output logic [adc_ctl_pkg::BUS_W-1:0] d);
		@(posedge i_core_clk);
		o_sel_n <= 1'b0;
		o_rd_n <= 1'b0;
		o_read_target_sel <= t;
		repeat (2) @(posedge i_core_clk);
		d = i_data;
		o_sel_n <= 1'b1;
		o_rd_n <= 1'b1;
		o_read_target_sel <= 1'b1;
	endtask : pin_read

	// requests set before the select rise, the next select fall acts
	task automatic set_cal(input logic b, input logic i);
		@(posedge i_core_clk);
		o_burst_cal <= b;
		o_interleave_tune_n <= i;
		o_sel_n <= 1'b0;
		@(posedge i_core_clk);
		o_sel_n <= 1'b1;
		@(posedge i_core_clk);
		o_sel_n <= 1'b0;
		@(posedge i_core_clk);
		o_sel_n <= 1'b1;
	endtask : set_cal

	// hold, select and address low together on purpose
	task automatic soft_reset();
		@(posedge i_core_clk);
		o_hold_n <= 1'b0;
		o_sel_n <= 1'b0;
		o_read_target_sel <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		o_hold_n <= 1'b1;
		o_sel_n <= 1'b1;
		o_read_target_sel <= 1'b1;
	endtask : soft_reset
endmodule : host_model

// ---- bench/adc_control_interface_tb_top.sv ----
/*
 * Self-checking bench: APB master tasks, host pin model, conversions and resets.
 * Assumes a 25 MHz core clock and a shortened reset calibration.
 */
`timescale 1ns/1ps
module adc_control_interface_tb_top;
	localparam int CAL = 40;
	logic clk;
	logic srst = 1'b1;
	logic rst_pin = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [11:0] sar = 12'h5a3;
	logic [14:0] calw = 15'h1234;
	logic [15:0] data;
	logic pready, pslverr, err, hold_n, sel_n, rd_n, tsel, burst, intl_n, oe, cd_n, td_n, irq;
	int fails = 0;
	int checks = 0;
	int cyc = 0;

	adc_control_interface #(.CAL_CYCLES(CAL)) u_dut (
		.i_core_clk(clk), .i_srst(srst), .i_ce(1'b1), .i_hold_n(hold_n), .i_sel_n(sel_n),
		.i_rd_n(rd_n), .i_read_target_sel(tsel), .i_rst_pin(rst_pin), .i_burst_cal(burst),
		.i_interleave_tune_n(intl_n), .i_sar_result(sar), .i_cal_word(calw), .o_data(data),
		.o_data_oe(oe), .o_conv_done_n(cd_n), .o_tracking_done_n(td_n), .o_irq(irq),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr)
	);

	host_model u_host (
		.i_core_clk(clk), .i_data(oe ? data : ~data), .o_hold_n(hold_n), .o_sel_n(sel_n),
		.o_rd_n(rd_n),
		.o_read_target_sel(tsel), .o_burst_cal(burst), .o_interleave_tune_n(intl_n)
	);

	// clock and run limit
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			fails++;
			end_sim();
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	// one apb transfer, held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic to_cd(input logic v, inout int n);
		while (cd_n !== v && n < 400) begin
			@(posedge clk);
			n++;
		end
	endtask : to_cd

	// edges between two falls of conversion done
	task automatic period(output int p);
		p = 0;
		to_cd(1'b1, p);
		to_cd(1'b0, p);
		p = 0;
		to_cd(1'b1, p);
		to_cd(1'b0, p);
	endtask : period

	task automatic end_sim();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		logic [15:0] pd;
		int n;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		n = 0;
		to_cd(1'b0, n);
		cmp("cal_end_done", 32'h0, cd_n);
		cmp("idle_oe", 32'h0, oe);
		apb(1'b0, adc_ctl_pkg::ADDR_TRIM, 32'h0, d);
		cmp("trim", 32'h0000_1234, d);
		u_host.set_cal(1'b0, 1'b1);
		apb(1'b1, adc_ctl_pkg::ADDR_IRQ_MASK, 32'h0000_0001, d);
		apb(1'b1, adc_ctl_pkg::ADDR_IRQ_STAT, 32'h0000_0007, d);
		apb(1'b0, adc_ctl_pkg::ADDR_IRQ_STAT, 32'h0, d);
		cmp("irq_stat_clr", 32'h0, d);
		cmp("irq_idle", 32'h0, irq);
		$display("test reset done");
		u_host.convert();
		n = 0;
		to_cd(1'b0, n);
		cmp("conv_done", 32'h0, cd_n);
		repeat (30) @(posedge clk);
		cmp("irq_conv", 32'h1, irq);
		cmp("tracked", 32'h0, td_n);
		u_host.pin_read(1'b1, pd);
		cmp("pin_data", 32'h0000_5a30, pd);
		cmp("rearm", 32'h1, cd_n);
		u_host.pin_read(1'b0, pd);
		cmp("pin_status", 32'h0000_0010, pd);
		apb(1'b0, adc_ctl_pkg::ADDR_RESULT, 32'h0, d);
		cmp("result", 32'h0000_05a3, d);
		apb(1'b0, 8'h20, 32'h0, d);
		cmp("unmapped_err", 32'h1, err);
		cmp("unmapped_data", 32'h0, d);
		apb(1'b1, adc_ctl_pkg::ADDR_IRQ_STAT, 32'h0000_0001, d);
		repeat (2) @(posedge clk);
		cmp("irq_cleared", 32'h0, irq);
		$display("test conversion done");
		u_host.set_cal(1'b0, 1'b0);
		apb(1'b0, adc_ctl_pkg::ADDR_STATUS, 32'h0, d);
		cmp("intl_on", 32'h1, d[adc_ctl_pkg::STS_INTL]);
		apb(1'b1, adc_ctl_pkg::ADDR_CTRL, 32'h0000_0001, d);
		period(n);
		cmp("loop_intl", 84, n);
		apb(1'b1, adc_ctl_pkg::ADDR_CTRL, 32'h0, d);
		u_host.set_cal(1'b0, 1'b1);
		apb(1'b0, adc_ctl_pkg::ADDR_STATUS, 32'h0, d);
		cmp("intl_off", 32'h0, d[adc_ctl_pkg::STS_INTL]);
		apb(1'b1, adc_ctl_pkg::ADDR_CTRL, 32'h0000_0001, d);
		period(n);
		cmp("loop_norm", adc_ctl_pkg::LOOP_CYCLES, n);
		apb(1'b1, adc_ctl_pkg::ADDR_CTRL, 32'h0, d);
		repeat (100) @(posedge clk);
		$display("test loopback done");
		u_host.set_cal(1'b1, 1'b1);
		repeat (5) @(posedge clk);
		apb(1'b0, adc_ctl_pkg::ADDR_STATUS, 32'h0, d);
		cmp("burst_on", 32'h1, d[adc_ctl_pkg::STS_BURST]);
		u_host.set_cal(1'b0, 1'b1);
		apb(1'b0, adc_ctl_pkg::ADDR_STATUS, 32'h0, d);
		cmp("burst_off", 32'h0, d[adc_ctl_pkg::STS_BURST]);
		$display("test burst done");
		for (int k = 0; k < 2; k++) begin
			if (k == 0) begin
				@(posedge clk);
				rst_pin <= 1'b1;
				repeat (3) @(posedge clk);
				rst_pin <= 1'b0;
			end else begin
				u_host.soft_reset();
			end
			@(posedge clk);
			cmp("reset_done_high", 32'h1, cd_n);
			n = 0;
			to_cd(1'b0, n);
			cmp("recal_done", 32'h0, cd_n);
		end
		$display("test resets done");
		end_sim();
	end
endmodule : adc_control_interface_tb_top
